//--- hpm_pkg.sv
package hpm_pkg;

  // ****************************************************************
  // widths and window
  // ****************************************************************
  localparam int AW            = 18;  // dedicated host address bus
  localparam int DW            = 16;  // host data bus
  localparam int WIN_WORDS     = 16;  // shared word window behind the port
  localparam int WIN_IDX_W     = 4;
  localparam int BUSY_W        = 2;

  // ****************************************************************
  // avalon register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // write 1 raises a host interrupt
  localparam logic [7:0] OFS_STATUS = 8'h04;  // sticky events, read only
  localparam logic [7:0] OFS_CLEAR  = 8'h08;  // write 1 clears a status bit
  localparam logic [7:0] OFS_ENABLE = 8'h0c;  // interrupt enable
  localparam logic [7:0] OFS_STATE  = 8'h10;  // live port state
  localparam logic [7:0] OFS_WIN    = 8'h40;  // 16 words, 0x40..0x7c
  localparam logic [7:0] WIN_MASK   = 8'hc3;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CB_IRQ_A    = 0;  // host control: pending / clear, sub a
  localparam int CB_IRQ_B    = 1;  // host control: pending / clear, sub b
  localparam int CB_DSPINT_A = 2;  // host control: interrupt sub a
  localparam int CB_DSPINT_B = 3;  // host control: interrupt sub b
  localparam int EV_DSPINT_A = 0;
  localparam int EV_DSPINT_B = 1;
  localparam int EV_HWRITE   = 2;
  localparam int EV_HREAD    = 3;
  localparam int EV_W        = 4;
  localparam int SB_MUX      = 0;  // state: multiplexed mode
  localparam int SB_ACTIVE   = 1;  // state: pins serve the host port
  localparam int SB_FLOAT_N  = 2;  // state: global float level
  localparam int SB_ADDR_LSB = 14; // state: host address in 31:14

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS  = 40;
  localparam int BUSY_NS = 80;  // ready low after each host transfer
  localparam logic [BUSY_W-1:0] BUSY_CYC = BUSY_W'((BUSY_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {SEL_CTRL, SEL_DATA_INC, SEL_ADDR, SEL_DATA} hpm_sel_t;

  typedef struct packed {
    logic          mux_sel_n;   // host_bus_mux_select, low = multiplexed
    logic          func_sel;    // port_function_select, low = host port
    logic          float_n;     // global output float, low = float
    logic          reset_n;     // host_port_reset_n
    logic          cs_n;        // host_chip_select_n
    logic          as_n;        // address strobe
    logic          ds_n;        // data strobe
    logic          rnw;         // 1 = host read
    logic [1:0]    cntl;        // register select, multiplexed mode
    logic [DW-1:0] data;
    logic [AW-1:0] addr;
  } hpm_pins_t;

  typedef struct packed {
    logic          irq_a;       // host_irq_out_sub_a level
    logic          irq_a_oe_n;
    logic          irq_b;       // host_irq_out_sub_b level
    logic          irq_b_oe_n;
    logic          rdy;         // host_ready_out
    logic          rdy_oe_n;
    logic [DW-1:0] data;
    logic          data_oe_n;
  } hpm_pin_out_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } hpm_avl_req_t;

endpackage : hpm_pkg

//--- hpm_host_port.sv
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns

// Behaviour
// - host interrupt pin driven low to signal
// - host writing one clears pending interrupt
// - host interrupts only in multiplexed mode
// - float input low floats both interrupt pins
// - reset pin resets port and both subsystems
// - mode pin low selects multiplexed mode
// - multiplexed host reaches control, address, data
// - multiplexed mode interrupts in both directions
// - mode pin high selects nonmultiplexed mode
// - nonmultiplexed: 18-bit address, 16-bit data
// - nonmultiplexed mode has no interrupts
// - address strobe latches host address register
// - pins serve host only when select low
// - ready output paces the next transfer
module hpm_host_port (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ce_in,
  input  wire hpm_pkg::hpm_pins_t    pins_in,
  input  wire hpm_pkg::hpm_avl_req_t avs_in,
  output logic [31:0]                avs_readdata_out,
  output logic                       avs_waitrequest_out,
  output logic                       irq_out,
  output hpm_pkg::hpm_pin_out_t      pins_out,
  output logic                       subsys_a_reset_out,
  output logic                       subsys_b_reset_out
);
  import hpm_pkg::*;

  // ****************************************************************
  // overview
  // ****************************************************************
  // host pins are asynchronous, so the whole pin struct passes two
  // flip-flops before any decode reads it; the price is about three
  // cycles from a pin edge to its effect, which the host absorbs by
  // waiting for ready before each transfer
  // strobes are edge-detected on the second stage only, so a pulse
  // shorter than a clock period can be missed; hosts hold the data
  // strobe low for at least four clocks and high for at least three
  // in multiplexed mode the address strobe loads only the low 16 bits of
  // the host address; the increment select carries into the top bits
  // in nonmultiplexed mode the low address pins pick the window word
  // and every access goes to the data register
  // the processor side is the avalon slave: it raises host interrupts
  // through the control offset, reads the event flags and reaches the
  // same word window that the host reads and writes
  // a host write and a processor write to one window word in one cycle
  // resolve in favour of the processor, whose assignment comes last
  // leaving multiplexed mode drops both pending host interrupts, as the
  // interrupt pins mean nothing to a host on separate buses
  // the port reset pin clears port state but keeps the enable mask and
  // the window, so software need not reprogram them after a host reset
  // clock enable low freezes every register, synchronisers included,
  // which also stalls the avalon handshake until it rises again
  // strobes that arrive while ready is low are still taken; pacing is
  // the host's duty, and a strobe too soon restarts the busy count

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    hpm_pins_t                          sync1;    // first stage, read by sync2 only
    hpm_pins_t                          sync2;
    logic                               prev_ds_n;
    logic                               prev_as_n;
    logic [AW-1:0]                      haddr;    // host_address_reg
    logic                               pend_a;
    logic                               pend_b;
    logic [DW-1:0]                      rdata;    // host read data
    logic [BUSY_W-1:0]                  busy;
    logic [EV_W-1:0]                    status;
    logic [EV_W-1:0]                    enable;
    logic [WIN_WORDS-1:0][DW-1:0]       win;
    logic                               ack;
    logic [31:0]                        avs_rdata;
    logic                               sub_rst;
  } hpm_state_t;

  localparam hpm_state_t ST_RESET = '0;

  hpm_state_t q;
  hpm_state_t d;

  // window decode, shared by bus read and write paths
  function automatic logic win_hit(input logic [7:0] a);
    return (a & WIN_MASK) == OFS_WIN;
  endfunction : win_hit

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    hpm_pins_t            p;
    logic                 mux_mode;
    logic                 active;
    logic                 ds_fall;
    logic                 as_fall;
    logic                 bus_req;
    logic                 bus_go;
    hpm_sel_t             sel;
    logic [WIN_IDX_W-1:0] hidx;
    logic [WIN_IDX_W-1:0] aidx;
    logic [EV_W-1:0]      ev;
    logic [EV_W-1:0]      clr;
    logic                 clr_a;
    logic                 clr_b;
    logic                 set_a;
    logic                 set_b;
    p        = q.sync2;
    mux_mode = ~p.mux_sel_n;
    active   = ~p.func_sel & p.reset_n;
    ds_fall  = active & ~p.cs_n & q.prev_ds_n & ~p.ds_n;
    as_fall  = active & mux_mode & ~p.cs_n & q.prev_as_n & ~p.as_n;
    bus_req  = avs_in.read | avs_in.write;
    bus_go   = bus_req & q.ack;
    sel      = hpm_sel_t'(p.cntl);
    hidx     = mux_mode ? q.haddr[WIN_IDX_W-1:0] : p.addr[WIN_IDX_W-1:0];
    aidx     = avs_in.address[WIN_IDX_W+1:2];
    ev       = '0;
    clr      = '0;
    clr_a    = 1'b0;
    clr_b    = 1'b0;
    set_a    = 1'b0;
    set_b    = 1'b0;

    d           = q;
    d.sync1     = pins_in;
    d.sync2     = q.sync1;
    d.prev_ds_n = p.ds_n;
    d.prev_as_n = p.as_n;
    d.sub_rst   = ~p.reset_n;

    // ready stays low a fixed time after each transfer
    if (q.busy != '0) begin
      d.busy = q.busy - BUSY_W'(1);
    end

    // address phase of a multiplexed host
    if (as_fall) begin
      d.haddr[DW-1:0] = p.data;
    end

    // data phase; strobes seen while busy are the host's fault
    if (ds_fall) begin
      d.busy = BUSY_CYC;
      ev[p.rnw ? EV_HREAD : EV_HWRITE] = 1'b1;
      if (mux_mode) begin
        unique case (sel)
          SEL_CTRL: begin
            if (p.rnw) begin
              d.rdata              = '0;
              d.rdata[CB_IRQ_A]    = q.pend_a;
              d.rdata[CB_IRQ_B]    = q.pend_b;
            end else begin
              clr_a                = p.data[CB_IRQ_A];
              clr_b                = p.data[CB_IRQ_B];
              ev[EV_DSPINT_A]      = p.data[CB_DSPINT_A];
              ev[EV_DSPINT_B]      = p.data[CB_DSPINT_B];
            end
          end
          SEL_ADDR: begin
            if (p.rnw) begin
              d.rdata = q.haddr[DW-1:0];
            end else begin
              d.haddr[DW-1:0] = p.data;
            end
          end
          SEL_DATA, SEL_DATA_INC: begin
            if (p.rnw) begin
              d.rdata = q.win[hidx];
            end else begin
              d.win[hidx] = p.data;
            end
            if (sel == SEL_DATA_INC) begin
              d.haddr = d.haddr + AW'(1);
            end
          end
        endcase
      end else begin
        // separate buses: address from pins, data register only
        if (p.rnw) begin
          d.rdata = q.win[hidx];
        end else begin
          d.win[hidx] = p.data;
        end
      end
    end

    // ****************************************************************
    // avalon slave, one wait state on every access
    // ****************************************************************
    d.ack = bus_req & ~q.ack;
    if (bus_req & ~q.ack) begin
      d.avs_rdata = '0;
      if (win_hit(avs_in.address)) begin
        d.avs_rdata[DW-1:0] = q.win[aidx];
      end else begin
        unique case (avs_in.address)
          OFS_CTRL: begin
            d.avs_rdata[CB_IRQ_A] = q.pend_a;
            d.avs_rdata[CB_IRQ_B] = q.pend_b;
          end
          OFS_STATUS: d.avs_rdata[EV_W-1:0] = q.status;
          OFS_ENABLE: d.avs_rdata[EV_W-1:0] = q.enable;
          OFS_STATE: begin
            d.avs_rdata[SB_MUX]                   = mux_mode;
            d.avs_rdata[SB_ACTIVE]                = active;
            d.avs_rdata[SB_FLOAT_N]               = p.float_n;
            d.avs_rdata[SB_ADDR_LSB+AW-1:SB_ADDR_LSB] = q.haddr;
          end
          default: d.avs_rdata = '0;            // unmapped reads zero
        endcase
      end
    end
    if (bus_go & avs_in.write) begin
      if (win_hit(avs_in.address)) begin
        if (avs_in.byteenable[0]) begin
          d.win[aidx][7:0] = avs_in.writedata[7:0];
        end
        if (avs_in.byteenable[1]) begin
          d.win[aidx][15:8] = avs_in.writedata[15:8];
        end
      end else if (avs_in.byteenable[0]) begin
        unique case (avs_in.address)
          OFS_CTRL: begin
            // processor raises host interrupts, multiplexed mode only
            set_a = avs_in.writedata[CB_IRQ_A] & mux_mode;
            set_b = avs_in.writedata[CB_IRQ_B] & mux_mode;
          end
          OFS_CLEAR:  clr = avs_in.writedata[EV_W-1:0];
          OFS_ENABLE: d.enable = avs_in.writedata[EV_W-1:0];
          default: ;
        endcase
      end
    end

    // a set arriving with its clear wins; pin held until cleared
    d.pend_a = (q.pend_a & ~clr_a) | set_a;
    d.pend_b = (q.pend_b & ~clr_b) | set_b;
    if (!mux_mode) begin
      d.pend_a = 1'b0;
      d.pend_b = 1'b0;
      ev[EV_DSPINT_A] = 1'b0;
      ev[EV_DSPINT_B] = 1'b0;
    end
    d.status = (q.status & ~clr) | ev;

    // reset pin clears the port but leaves the synchronisers running
    if (!p.reset_n) begin
      d.haddr  = '0;
      d.pend_a = 1'b0;
      d.pend_b = 1'b0;
      d.rdata  = '0;
      d.busy   = '0;
      d.status = '0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // reset wins over the clock enable, so a frozen block still resets
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      q <= ST_RESET;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // enables depend on synced levels only, so they change on clock edges
  logic irq_drive;
  logic port_drive;
  assign port_drive = ~q.sync2.func_sel & q.sync2.float_n;
  assign irq_drive  = port_drive & ~q.sync2.mux_sel_n;

  // irq and data levels come straight from registers, so they never glitch; ready is decoded from busy and reset_n
  assign pins_out.irq_a      = ~q.pend_a;
  assign pins_out.irq_b      = ~q.pend_b;
  assign pins_out.irq_a_oe_n = ~irq_drive;
  assign pins_out.irq_b_oe_n = ~irq_drive;
  assign pins_out.rdy        = (q.busy == '0) & q.sync2.reset_n;
  assign pins_out.rdy_oe_n   = ~port_drive;
  assign pins_out.data       = q.rdata;
  // host read drives data only while chip select and strobe hold
  assign pins_out.data_oe_n  = ~(port_drive & ~q.sync2.cs_n & ~q.sync2.ds_n
                                 & q.sync2.rnw & q.sync2.reset_n);

  assign avs_waitrequest_out = (avs_in.read | avs_in.write) & ~q.ack;
  assign avs_readdata_out    = q.avs_rdata;
  assign irq_out             = |(q.status & q.enable);
  assign subsys_a_reset_out  = q.sub_rst;
  assign subsys_b_reset_out  = q.sub_rst;

endmodule : hpm_host_port

//--- hpm_host_port_asserts.sv
`timescale 1ns/1ns
// *****
// port rule checker
// *****
module hpm_chk (
  input wire logic                  core_clk_in,
  input wire logic                  rst_in,
  input wire hpm_pkg::hpm_pins_t    pins_in,
  input wire hpm_pkg::hpm_avl_req_t avs_in,
  input wire logic                  avs_waitrequest_out,
  input wire hpm_pkg::hpm_pin_out_t pins_out,
  input wire logic                  subsys_a_reset_out,
  input wire logic                  subsys_b_reset_out
);
  import hpm_pkg::*;
  // pins pass two sync flops, so level rules get five cycles to settle
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  a_float_hiz: assert property (
    (!pins_in.float_n)[*5] |-> pins_out.irq_a_oe_n && pins_out.irq_b_oe_n)
    else $error("irq pins driven while floating");
  a_nonmux_quiet: assert property (
    pins_in.mux_sel_n[*5] |-> pins_out.irq_a_oe_n && pins_out.irq_b_oe_n)
    else $error("irq pins driven in nonmux mode");
  a_mux_drive: assert property (
    (!pins_in.mux_sel_n && pins_in.float_n && !pins_in.func_sel)[*5]
    |-> !pins_out.irq_a_oe_n && !pins_out.irq_b_oe_n)
    else $error("irq pins idle in mux mode");
  a_func_off: assert property (
    pins_in.func_sel[*5] |-> pins_out.rdy_oe_n && pins_out.data_oe_n)
    else $error("pins driven while deselected");
  a_pin_reset: assert property (
    (!pins_in.reset_n)[*5] |-> subsys_a_reset_out && subsys_b_reset_out)
    else $error("subsystem reset missing");
  a_reset_busy: assert property (
    (!pins_in.reset_n)[*5] |-> !pins_out.rdy)
    else $error("ready high in port reset");
  a_raise_irq: assert property (
    avs_in.write && !avs_waitrequest_out && avs_in.address == OFS_CTRL && avs_in.byteenable[0]
    && avs_in.writedata[0] && !pins_out.irq_a_oe_n |=> !pins_out.irq_a)
    else $error("irq a not raised");
  a_irq_hold: assert property (
    $fell(pins_out.irq_a) |=> (!pins_out.irq_a)[*3])
    else $error("irq a pulse too short");
  a_one_wait: assert property (
    (avs_in.read || avs_in.write) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait state not one cycle");
  c_irq_set: cover property ($fell(pins_out.irq_a));
  c_irq_clr: cover property ($rose(pins_out.irq_a));
  c_busy: cover property ($fell(pins_out.rdy));
endmodule : hpm_chk

bind hpm_host_port hpm_chk u_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .pins_in(pins_in), .avs_in(avs_in),
  .avs_waitrequest_out(avs_waitrequest_out), .pins_out(pins_out),
  .subsys_a_reset_out(subsys_a_reset_out), .subsys_b_reset_out(subsys_b_reset_out)
);

//--- hpm_host_model.sv
`timescale 1ns/1ns
// *****
// host processor model
// *****
module hpm_host_model (
  input  wire logic                  core_clk_in,
  input  wire hpm_pkg::hpm_pin_out_t dev_in,
  output hpm_pkg::hpm_pins_t         host_out
);
  import hpm_pkg::*;
  // idle: mux mode, port selected, not floating, out of reset, strobes high
  hpm_pins_t p = 44'h3f000000000;
  // the data wire carries the device value only while it drives
  always_comb begin
    host_out = p;
    if (!dev_in.data_oe_n) begin
      host_out.data = dev_in.data;
    end
  end
  // one transfer; s picks the address strobe instead of the data strobe
  task automatic xfer(input logic s, input logic [1:0] c, input logic r,
                      input logic [17:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge core_clk_in);
    while (dev_in.rdy !== 1'b1) begin
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    p.cs_n <= 1'b0;
    p.cntl <= c;
    p.rnw <= r;
    p.addr <= a;
    p.data <= d;
    @(posedge core_clk_in);
    if (s) p.as_n <= 1'b0;
    else p.ds_n <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    q = host_out.data;
    p.as_n <= 1'b1;
    p.ds_n <= 1'b1;
    p.cs_n <= 1'b1;
    // released lines show the inverse so a stale value cannot pass
    p.data <= ~d;
    p.addr <= ~a;
    repeat (4) @(posedge core_clk_in);
  endtask : xfer
  // board level pins: mux_sel_n, func_sel, float_n, reset_n
  task automatic mode(input logic [3:0] m);
    @(posedge core_clk_in);
    {p.mux_sel_n, p.func_sel, p.float_n, p.reset_n} <= m;
    repeat (6) @(posedge core_clk_in);
  endtask : mode
endmodule : hpm_host_model

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
  import hpm_pkg::*;
  typedef logic [19:0] hpm_row_t;  // window index, word
  logic         clk, rst, ce, wreq, irq, sra, srb;
  hpm_avl_req_t avs;
  hpm_pins_t    pins;
  hpm_pin_out_t po;
  logic [31:0]  rd, r;
  logic [15:0]  q;
  int           n_errors = 0;
  int           num_checks = 0;
  int           cyc = 0;
  hpm_row_t     rows [4] = '{20'h01234, 20'h7ffff, 20'hf0c0f, 20'h3a5c3};
  hpm_host_port uut (.core_clk_in(clk), .rst_in(rst), .ce_in(ce), .pins_in(pins),
    .avs_in(avs), .avs_readdata_out(rd), .avs_waitrequest_out(wreq), .irq_out(irq),
    .pins_out(po), .subsys_a_reset_out(sra), .subsys_b_reset_out(srb));
  hpm_host_model host (.core_clk_in(clk), .dev_in(po), .host_out(pins));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one avalon access, held until waitrequest is seen low
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    avs.write <= w;
    avs.read <= !w;
    avs.address <= a;
    avs.writedata <= d;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rd;
    avs.write <= 1'b0;
    avs.read <= 1'b0;
    @(posedge clk);
  endtask : av
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, far above the planned run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    avs = '0;
    avs.byteenable = 4'hf;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk({30'h0, sra, srb}, 32'h0);
    chk({30'h0, po.irq_a, po.irq_b}, 32'h3);
    av(1'b0, OFS_STATUS, 32'h0, r);
    chk(r, 32'h0);
    foreach (rows[k]) begin
      host.xfer(1'b1, 2'h2, 1'b0, 18'h0, {12'h0, rows[k][19:16]}, q);
      host.xfer(1'b0, 2'h3, 1'b0, 18'h0, rows[k][15:0], q);
      av(1'b0, OFS_WIN + {2'h0, rows[k][19:16], 2'h0}, 32'h0, r);
      chk(r, {16'h0, rows[k][15:0]});
      host.xfer(1'b0, 2'h1, 1'b1, 18'h0, 16'h0, q);
      chk({16'h0, q}, {16'h0, rows[k][15:0]});
      host.xfer(1'b0, 2'h2, 1'b1, 18'h0, 16'h0, q);
      chk({16'h0, q}, 32'(rows[k][19:16]) + 32'h1);
      av(1'b0, OFS_STATE, 32'h0, r);
      chk(r & 32'hffffc007, ((32'(rows[k][19:16]) + 32'h1) << 14) | 32'h7);
    end
    // clock enable low freezes the port, so this host write is lost
    ce <= 1'b0;
    host.xfer(1'b0, 2'h3, 1'b0, 18'h0, 16'h5555, q);
    ce <= 1'b1;
    av(1'b0, OFS_WIN + 8'h10, 32'h0, r);
    chk(r, 32'h0);
    // both interrupt directions, masking and clearing
    av(1'b1, OFS_ENABLE, 32'hf, r);
    av(1'b1, OFS_CLEAR, 32'hf, r);
    av(1'b1, OFS_CTRL, 32'h3, r);
    chk({30'h0, po.irq_a, po.irq_b}, 32'h0);
    host.xfer(1'b0, 2'h0, 1'b1, 18'h0, 16'h0, q);
    chk({30'h0, q[1:0]}, 32'h3);
    host.xfer(1'b0, 2'h0, 1'b0, 18'h0, 16'h5, q);
    chk({30'h0, po.irq_a, po.irq_b}, 32'h2);
    av(1'b0, OFS_STATUS, 32'h0, r);
    chk({r, 30'h0, irq}, {32'hd, 31'h1});
    av(1'b1, OFS_ENABLE, 32'h0, r);
    chk({31'h0, irq}, 32'h0);
    av(1'b1, OFS_CLEAR, 32'hf, r);
    av(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    // port reset pin drops the pending interrupt and resets both subsystems
    host.mode(4'b0010);
    chk({29'h0, sra, srb, po.rdy}, 32'h6);
    host.mode(4'b0011);
    chk({29'h0, sra, srb, po.irq_b}, 32'h1);
    host.mode(4'b0001);
    chk({30'h0, po.irq_a_oe_n, po.irq_b_oe_n}, 32'h3);
    // nonmultiplexed host: no interrupts, direct address bus
    host.mode(4'b1011);
    av(1'b1, OFS_CTRL, 32'h3, r);
    chk({30'h0, po.irq_a_oe_n, po.irq_a}, 32'h3);
    av(1'b0, OFS_STATE, 32'h0, r);
    chk({29'h0, r[2:0]}, 32'h6);
    host.xfer(1'b0, 2'h0, 1'b0, 18'h00009, 16'hbeef, q);
    av(1'b0, 8'h64, 32'h0, r);
    chk(r, 32'hbeef);
    host.mode(4'b1111);
    host.xfer(1'b0, 2'h0, 1'b0, 18'h00009, 16'h1111, q);
    av(1'b0, 8'h64, 32'h0, r);
    chk({r[30:0], po.rdy_oe_n}, {31'hbeef, 1'b1});
    print_verdict();
  end
endmodule : testbench
